// *** design/adcsq_pkg.sv ***
// Purpose: Shared constants and types of the converter sequencer control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: Registers are 8 bits wide and sit in the low byte of their word
package adcsq_pkg;
    localparam int ADDR_W = 8;
    localparam int RES_W = 12;
    // Register byte addresses
    localparam logic [7:0] OFF_RES_LOW = 8'h00;
    localparam logic [7:0] OFF_RES_HIGH = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_SRC = 8'h0c;
    localparam logic [7:0] OFF_REF = 8'h10;
    localparam logic [7:0] OFF_BG = 8'h14;
    localparam logic [7:0] OFF_INT_STATUS = 8'h18;
    localparam logic [7:0] OFF_INT_MASK = 8'h1c;
    // converter_control fields
    localparam int START_BIT = 7;
    localparam int BUSY_BIT = 6;
    localparam int ENABLE_BIT = 5;
    localparam int JUSTIFY_BIT = 4;
    localparam int CHAN_LSB = 0;
    // input_source_control fields
    localparam int SRC_LSB = 4;
    localparam int DIV_LSB = 0;
    // Writable bit masks, reserved bits read as zero
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    localparam logic [7:0] SRC_WMASK = 8'hf7;
    localparam logic [7:0] REF_WMASK = 8'h9f;
    localparam logic [7:0] BG_WMASK = 8'h01;
    localparam logic [7:0] INT_WMASK = 8'h01;
    localparam int DONE_EVT_BIT = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;
    localparam logic [7:0] REF_RST = 8'h00;
    localparam logic [7:0] BG_RST = 8'h00;
    localparam logic [7:0] INT_RST = 8'h00;
    localparam logic [11:0] RES_RST = 12'h000;
    localparam logic [11:0] SAR_FIRST = 12'h800;
    localparam logic [3:0] CHAN_HIGHEST = 4'h8;
    localparam logic [3:0] CHAN_RSVD = 4'h2;
    localparam logic [1:0] SRC_GND_TOP = 2'b10;
    localparam int SAMPLE_TICKS_DEF = 4;
    localparam int PINS = 9;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11,
        ST_DONE = 2'b10
    } adcsq_state_type;
endpackage

// *** design/adcsq_top.sv ***
// Purpose: Digital sequencer of a 12-bit successive-approximation converter
// Assumes: Analog comparator, DAC and muxes sit outside; inputs synchronous to mclk
// Notes: Registers over AHB-Lite, zero wait states, one level interrupt
`timescale 1ns/1ns
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int SAMPLE_TICKS = SAMPLE_TICKS_DEF
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic comp_hi,
    input wire logic [PINS-1:0] pin_analog_assign,
    output logic irq,
    output logic conv_power_on,
    output logic sample_hold,
    output logic [RES_W-1:0] dac_code,
    output logic ext_route_en,
    output logic [3:0] ext_channel_sel,
    output logic [3:0] int_route_sel,
    output logic ground_sel,
    output logic [PINS-1:0] pin_digital_off,
    output logic [1:0] reference_sel,
    output logic gain_amp_enable,
    output logic gain_amp_input_sel,
    output logic [1:0] gain_amp_gain_sel,
    output logic bandgap_enable
);

    adcsq_state_type state;
    logic [7:0] ctrl;
    logic [7:0] src;
    logic [7:0] ref_gain;
    logic [7:0] bg;
    logic [7:0] int_status;
    logic [7:0] int_mask;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] sar_code;
    logic [3:0] bit_idx;
    logic [6:0] div_cnt;
    logic [7:0] sample_cnt;
    logic busy;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic addr_ok;
    logic wr_ctrl;
    logic start_fire;
    logic conv_tick;
    logic done_evt;
    logic rd_status;

    // Channel code connects an existing pin
    function automatic logic chan_valid(input logic [3:0] code);
        chan_valid = (code <= CHAN_HIGHEST) && (code != CHAN_RSVD);
    endfunction

    // Source code 0000, 0100 or 11xx takes the external channel
    function automatic logic src_external(input logic [3:0] code);
        src_external = (code[3] == 1'b0 && code[1:0] == 2'b00) || (code[3:2] == 2'b11);
    endfunction

    function automatic logic src_ground(input logic [3:0] code);
        src_ground = (code[3:2] == SRC_GND_TOP);
    endfunction

    function automatic logic [7:0] fmt_high(input logic [11:0] r, input logic just);
        fmt_high = just ? {4'h0, r[11:8]} : r[11:4];
    endfunction

    function automatic logic [7:0] fmt_low(input logic [11:0] r, input logic just);
        fmt_low = just ? r[7:0] : {r[3:0], 4'h0};
    endfunction

    wire logic [3:0] chan_code = ctrl[CHAN_LSB +: 4];
    wire logic [3:0] src_code = src[SRC_LSB +: 4];
    wire logic [2:0] div_sel = src[DIV_LSB +: 3];
    wire logic conv_en = ctrl[ENABLE_BIT];
    wire logic justify = ctrl[JUSTIFY_BIT];
    wire logic [6:0] div_mask = 7'((8'h01 << div_sel) - 8'h01);

    assign addr_ok = hsel && htrans[1] && hready;
    assign wr_ctrl = wr_pend && (wr_addr == OFF_CTRL);
    // Start bit must have been high before this write brings it low
    assign start_fire = wr_ctrl && !hwdata[START_BIT] && ctrl[START_BIT];
    assign conv_tick = ((div_cnt & div_mask) == div_mask);
    assign done_evt = (state == ST_DONE);
    assign rd_status = addr_ok && !hwrite && (haddr[ADDR_W-1:0] == OFF_INT_STATUS);

    // Bus data phase tracking
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[ADDR_W-1:0];
        end
    end

    // Zero wait state slave, always OKAY
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data sampled in the address phase; a write just before is not forwarded
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            case (haddr[ADDR_W-1:0])
                OFF_RES_LOW: hrdata <= {24'h0, fmt_low(result, justify)};
                OFF_RES_HIGH: hrdata <= {24'h0, fmt_high(result, justify)};
                OFF_CTRL: hrdata <= {24'h0, ctrl[7], busy, ctrl[5:0]};
                OFF_SRC: hrdata <= {24'h0, src};
                OFF_REF: hrdata <= {24'h0, ref_gain};
                OFF_BG: hrdata <= {24'h0, bg};
                OFF_INT_STATUS: hrdata <= {24'h0, int_status};
                OFF_INT_MASK: hrdata <= {24'h0, int_mask};
                default: hrdata <= '0;
            endcase
        end
    end

    // Busy bit is not stored in ctrl, so writes cannot reach it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl <= CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl <= hwdata[7:0] & CTRL_WMASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            src <= SRC_RST;
            ref_gain <= REF_RST;
            bg <= BG_RST;
            int_mask <= INT_RST;
        end else if (wr_pend) begin
            case (wr_addr)
                OFF_SRC: src <= hwdata[7:0] & SRC_WMASK;
                OFF_REF: ref_gain <= hwdata[7:0] & REF_WMASK;
                OFF_BG: bg <= hwdata[7:0] & BG_WMASK;
                OFF_INT_MASK: int_mask <= hwdata[7:0] & INT_WMASK;
                default: ;
            endcase
        end
    end

    // Read clears, but a completion in the same cycle still sets
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            int_status <= INT_RST;
        end else begin
            int_status <= (rd_status ? 8'h00 : int_status) | {7'h0, done_evt};
        end
    end

    // One cycle behind the status bit to keep the output registered
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status & int_mask);
        end
    end

    // Divider restarts with every conversion so the first tick is predictable
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else if (state == ST_IDLE) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 7'h01;
        end
    end

    // Conversion sequencer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            sample_cnt <= '0;
            sar_code <= '0;
            bit_idx <= '0;
            sample_hold <= 1'b0;
        end else if (!conv_en) begin
            // Powered down: abort, no conversion
            state <= ST_IDLE;
            busy <= 1'b0;
            sample_hold <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    // A restart while busy cannot happen here; idle only
                    if (start_fire) begin
                        state <= ST_SAMPLE;
                        busy <= 1'b1;
                        sample_cnt <= '0;
                        sample_hold <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        if (sample_cnt == 8'(SAMPLE_TICKS - 1)) begin
                            state <= ST_CONVERT;
                            sample_hold <= 1'b0;
                            sar_code <= SAR_FIRST;
                            bit_idx <= 4'(RES_W - 1);
                        end else begin
                            sample_cnt <= sample_cnt + 8'h01;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (conv_tick) begin
                        // Comparator low means the trial bit overshot
                        if (bit_idx == 4'h0) begin
                            sar_code[0] <= comp_hi;
                            state <= ST_DONE;
                        end else begin
                            sar_code[bit_idx] <= comp_hi;
                            sar_code[bit_idx - 4'h1] <= 1'b1;
                            bit_idx <= bit_idx - 4'h1;
                        end
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
                default: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // Result loads in the same cycle busy falls; a DONE reached just as the converter is disabled loads nothing
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            result <= RES_RST;
        end else if (conv_en && done_evt) begin
            result <= sar_code;
        end
    end

    // Trial code leaves with no lag; a copied register would let the comparator judge the previous trial
    assign dac_code = sar_code;

    // Input routing; only one of the three paths may be active
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ext_route_en <= 1'b0;
            ext_channel_sel <= '0;
            int_route_sel <= '0;
            ground_sel <= 1'b0;
        end else begin
            ext_channel_sel <= chan_code;
            // Reserved and non-existent codes leave the input floating
            ext_route_en <= src_external(src_code) && chan_valid(chan_code);
            int_route_sel <= (src_external(src_code) || src_ground(src_code)) ? 4'h0 : src_code;
            ground_sel <= src_ground(src_code);
        end
    end

    // Pin sharing decides analog use; the pad drops digital and pull-high then
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_digital_off <= '0;
        end else begin
            pin_digital_off <= pin_analog_assign;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            conv_power_on <= 1'b0;
            reference_sel <= '0;
            gain_amp_enable <= 1'b0;
            gain_amp_input_sel <= 1'b0;
            gain_amp_gain_sel <= '0;
            bandgap_enable <= 1'b0;
        end else begin
            conv_power_on <= conv_en;
            gain_amp_enable <= ref_gain[7];
            gain_amp_input_sel <= ref_gain[4];
            reference_sel <= ref_gain[3:2];
            gain_amp_gain_sel <= ref_gain[1:0];
            bandgap_enable <= bg[0];
        end
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    chk_start_sets_busy: assert property (
        start_fire && conv_en && state == ST_IDLE |=> busy && state == ST_SAMPLE)
        else $error("busy did not rise after start sequence");

    chk_busy_needs_start: assert property (
        $rose(busy) |-> $past(start_fire) && $past(conv_en))
        else $error("busy rose without a completed start sequence");

    chk_busy_clears: assert property (
        state == ST_DONE && conv_en |=> !busy && state == ST_IDLE)
        else $error("busy not cleared after conversion end");

    chk_disabled_idle: assert property (
        !conv_en |=> !busy ##0 !conv_power_on)
        else $error("disabled converter still busy or powered");

    chk_results_held: assert property (
        !conv_en |=> $stable(result))
        else $error("result changed while disabled");

    chk_result_on_fall: assert property (
        $fell(busy) && $past(state) == ST_DONE && $past(conv_en) |-> result == $past(sar_code))
        else $error("result not loaded when busy fell");

    chk_low_zero_bits: assert property (
        addr_ok && !hwrite && haddr[7:0] == OFF_RES_LOW && !justify |=> hrdata[3:0] == 4'h0)
        else $error("low result nibble not zero in left justify");

    chk_high_zero_bits: assert property (
        addr_ok && !hwrite && haddr[7:0] == OFF_RES_HIGH && justify |=> hrdata[7:4] == 4'h0)
        else $error("high result nibble not zero in right justify");

    chk_one_path: assert property (
        $onehot0({ext_route_en, int_route_sel != 4'h0, ground_sel}))
        else $error("more than one source routed to the converter");

    chk_float_codes: assert property (
        chan_code >= 4'hc |=> !ext_route_en)
        else $error("non-existent channel routed");

    chk_sar_steps: assert property (
        $rose(state == ST_CONVERT) |-> bit_idx == 4'hb && sar_code == SAR_FIRST)
        else $error("conversion did not start at top bit");

endmodule // adcsq_top

// *** tb/adcsq_analog_model.sv ***
// Purpose: Analog side of the converter: input pins, internal levels, comparator
// Assumes: Ideal comparator; each source holds one fixed level
// Notes: An unrouted or powered-down input toggles the comparator every cycle
`timescale 1ns/1ns
module adcsq_analog_model
    import adcsq_pkg::*;
(
    input wire logic mclk,
    input wire logic conv_power_on,
    input wire logic [RES_W-1:0] dac_code,
    input wire logic ext_route_en,
    input wire logic [3:0] ext_channel_sel,
    input wire logic [3:0] int_route_sel,
    input wire logic ground_sel,
    input wire logic [PINS-1:0] pin_digital_off,
    output logic comp_hi
);
    logic flip = 1'b0;
    logic driven;
    logic [RES_W-1:0] level;
    always @(posedge mclk) begin
        flip <= ~flip;
    end
    always_comb begin
        driven = conv_power_on;
        level = 12'h000;
        if (ground_sel) begin
            level = 12'h000;
        end else if (int_route_sel != 4'h0) begin
            level = 12'h0f0 + 12'(int_route_sel) * 12'h211;
        end else if (ext_route_en && ext_channel_sel <= CHAN_HIGHEST && ext_channel_sel != CHAN_RSVD) begin
            level = 12'h123 + 12'(ext_channel_sel) * 12'h1c7;
            // Pin still digital: nothing reaches the converter
            driven = conv_power_on & pin_digital_off[ext_channel_sel];
        end else begin
            driven = 1'b0;
        end
    end
    // Floating input: no stable level, so no fixed answer either
    assign comp_hi = driven ? (level >= dac_code) : flip;
endmodule // adcsq_analog_model

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench of the converter sequencer control block
// Assumes: Zero-wait register bus; analog model on the comparator side
// Notes: Short sampling phase keeps conversions brief
`timescale 1ns/1ns
module tb_top;
    import adcsq_pkg::*;
    localparam int ST = 2;
    logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [PINS-1:0] pin_analog_assign = 9'h000, pin_digital_off;
    logic hreadyout, hresp, irq, conv_power_on, ext_route_en, ground_sel, comp_hi;
    logic sample_hold, gain_amp_enable, gain_amp_input_sel, bandgap_enable;
    logic [1:0] reference_sel, gain_amp_gain_sel;
    logic [RES_W-1:0] dac_code;
    logic [3:0] ext_channel_sel, int_route_sel;
    int error_cnt = 0, checks_done = 0;
    adcsq_top #(.SAMPLE_TICKS(ST)) dut_u (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_hi(comp_hi),
        .pin_analog_assign(pin_analog_assign), .irq(irq), .conv_power_on(conv_power_on),
        .sample_hold(sample_hold), .dac_code(dac_code), .ext_route_en(ext_route_en),
        .ext_channel_sel(ext_channel_sel), .int_route_sel(int_route_sel), .ground_sel(ground_sel),
        .pin_digital_off(pin_digital_off), .reference_sel(reference_sel), .gain_amp_enable(gain_amp_enable),
        .gain_amp_input_sel(gain_amp_input_sel), .gain_amp_gain_sel(gain_amp_gain_sel),
        .bandgap_enable(bandgap_enable));
    adcsq_analog_model model_u (.mclk(mclk), .conv_power_on(conv_power_on), .dac_code(dac_code),
        .ext_route_en(ext_route_en), .ext_channel_sel(ext_channel_sel),
        .int_route_sel(int_route_sel), .ground_sel(ground_sel), .pin_digital_off(pin_digital_off),
        .comp_hi(comp_hi));
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that runs out ends the run
    task automatic bound(input logic ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            conclude();
        end
    endtask
    // Ready and read data are taken at the rising edge, before the slave updates them
    task automatic wait_rdy(output logic [31:0] d);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        bound(hreadyout === 1'b1);
        d = hrdata;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy(rd);
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(rd);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, {24'h0, d}, x);
    endtask
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask
    task automatic wait_idle;
        logic [31:0] c;
        int n;
        n = 0;
        do begin
            rreg(OFF_CTRL, c);
            n++;
        end while (c[BUSY_BIT] !== 1'b0 && n < 3000);
        bound(c[BUSY_BIT] === 1'b0);
    endtask
    task automatic start(input logic [7:0] ctl);
        wreg(OFF_CTRL, ctl | 8'h80);
        wreg(OFF_CTRL, ctl);
    endtask
    task automatic convert(input logic [7:0] ctl);
        start(ctl);
        wait_idle();
    endtask
    function automatic logic [11:0] ext_lvl(input int ch);
        return 12'h123 + 12'(ch) * 12'h1c7;
    endfunction
    // Format is applied at read time, so one result serves both layouts
    task automatic chk_res(input logic [7:0] ctl, input logic [11:0] e);
        logic [31:0] lo, hi;
        wreg(OFF_CTRL, ctl & 8'hef);
        rreg(OFF_RES_HIGH, hi);
        rreg(OFF_RES_LOW, lo);
        check(hi, {24'h0, e[11:4]});
        check(lo, {24'h0, e[3:0], 4'h0});
        wreg(OFF_CTRL, ctl | 8'h10);
        rreg(OFF_RES_HIGH, hi);
        rreg(OFF_RES_LOW, lo);
        check(hi, {28'h0, e[11:8]});
        check(lo, {24'h0, e[7:0]});
    endtask
    task automatic t_regs;
        logic [31:0] d;
        logic [7:0] offs [4] = '{OFF_SRC, OFF_REF, OFF_BG, OFF_INT_MASK};
        logic [7:0] msk [4] = '{SRC_WMASK, REF_WMASK, BG_WMASK, INT_WMASK};
        for (int i = 0; i < 9; i++) begin
            rreg(8'(i * 4), d);
            check(d, 32'h0);
        end
        for (int i = 0; i < 4; i++) begin
            wreg(offs[i], 8'hff);
            rreg(offs[i], d);
            check(d, {24'h0, msk[i]});
            if (i == 1) begin
                check(32'({gain_amp_enable, gain_amp_input_sel, reference_sel, gain_amp_gain_sel}), 32'h3f);
            end else if (i == 2) begin
                check(32'(bandgap_enable), 32'h1);
            end
            wreg(offs[i], 8'h00);
        end
        wreg(OFF_CTRL, 8'h5f);
        rreg(OFF_CTRL, d);
        check(d, 32'h1f);
        check(32'(hresp), 32'h0);
        pin_analog_assign <= 9'h0a5;
        repeat (3) @(negedge mclk);
        check(32'(pin_digital_off), 32'h0a5);
        @(posedge mclk);
        pin_analog_assign <= 9'h1ff;
    endtask
    task automatic t_start;
        logic [31:0] d;
        wreg(OFF_CTRL, 8'h23);
        wreg(OFF_CTRL, 8'h23);
        rreg(OFF_CTRL, d);
        check(d, 32'h23);
        wreg(OFF_CTRL, 8'ha3);
        rreg(OFF_CTRL, d);
        check(d, 32'ha3);
        check(32'(conv_power_on), 32'h1);
        wreg(OFF_CTRL, 8'h23);
        rreg(OFF_CTRL, d);
        check(d, 32'h63);
        wait_idle();
        chk_res(8'h23, ext_lvl(3));
    endtask
    task automatic t_chan;
        logic [31:0] d;
        for (int ch = 0; ch < 16; ch++) begin
            if (ch == 2 || (ch >= 9 && ch <= 11)) continue;
            convert(8'h20 | 8'(ch));
            check(32'(ext_channel_sel), 32'(ch));
            if (ch < 12) begin
                check(32'(ext_route_en), 32'h1);
                chk_res(8'h20 | 8'(ch), ext_lvl(ch));
            end else begin
                rreg(OFF_CTRL, d);
                check(d, 32'h20 | 32'(ch));
                check(32'(ext_route_en), 32'h0);
            end
        end
    endtask
    task automatic t_src;
        logic gnd, intl;
        logic [11:0] e;
        for (int s = 0; s < 16; s++) begin
            wreg(OFF_SRC, 8'(s) << 4);
            convert(8'h24);
            gnd = (s >= 8 && s <= 11);
            intl = (s < 8) && (s % 4 != 0);
            e = gnd ? 12'h000 : (intl ? 12'h0f0 + 12'(s) * 12'h211 : ext_lvl(4));
            check(32'(ground_sel), 32'(gnd));
            check(32'(ext_route_en), 32'(!gnd && !intl));
            check(32'(int_route_sel), intl ? 32'(s) : 32'h0);
            chk_res(8'h24, e);
        end
        wreg(OFF_SRC, 8'h00);
    endtask
    task automatic t_irq;
        logic [31:0] d;
        int n;
        rreg(OFF_INT_STATUS, d);
        convert(8'h20);
        check(32'(irq), 32'h0);
        wreg(OFF_INT_MASK, 8'h01);
        repeat (3) @(negedge mclk);
        check(32'(irq), 32'h1);
        rreg(OFF_INT_STATUS, d);
        check(d, 32'h1);
        repeat (3) @(negedge mclk);
        check(32'(irq), 32'h0);
        rreg(OFF_INT_STATUS, d);
        check(d, 32'h0);
        for (int dv = 0; dv < 8; dv++) begin
            wreg(OFF_SRC, 8'(dv));
            start(8'h20);
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (irq !== 1'b1 && n < 4000);
            bound(irq === 1'b1);
            check(32'(n >= (ST + 11) << dv && n <= ((ST + 13) << dv) + 4), 32'h1);
            rreg(OFF_INT_STATUS, d);
        end
    endtask
    task automatic t_off;
        logic [31:0] d;
        wreg(OFF_SRC, 8'h00);
        start(8'h04);
        rreg(OFF_CTRL, d);
        check(d, 32'h04);
        check(32'(conv_power_on), 32'h0);
        chk_res(8'h04, ext_lvl(0));
        wreg(OFF_SRC, 8'h07);
        start(8'h24);
        @(negedge mclk);
        check(32'(sample_hold), 32'h1);
        wreg(OFF_CTRL, 8'h04);
        rreg(OFF_CTRL, d);
        check(d, 32'h04);
        check(32'(sample_hold), 32'h0);
        chk_res(8'h04, ext_lvl(0));
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_start();
        t_chan();
        t_src();
        t_irq();
        t_off();
        conclude();
    end
endmodule // tb_top
